// [verilog/device_pin_config_mux.sv]
// pin configuration register and shared pin multiplexer
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [RULE1] software writes zeros to bits 31:5
// [RULE2] bit 4 picks memory interface clock
// [RULE3] bit 3 gives timer b pin to audio
// [RULE4] bit 2 gives timer a pin to audio
// [RULE5] timers keep running when pins handed over
// [RULE6] each timer pin select acts independently
// [RULE7] bit 1 low: serial a owns pins
// [RULE8] bit 1 high: audio clock/frame pins enabled
// [RULE9] no audio clocks: transmitter mode only
// [RULE10] bit 0 low: serial b owns pins
// [RULE11] bit 0 high: twowire b, audio pins enabled
// [RULE12] rewrites take effect at any time
// [RULE13] host port pins set by strap only
// [RULE14] exactly one strapped peripheral owns pins
// [RULE15] register decoded over whole 256-byte window
// [RULE16] strap picks host port or alternates
// [RULE17] reads return last write, reset zero
module device_pin_config_mux (
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // reset strap
  input wire logic host_port_strap,
  output logic host_port_enable,
  output logic alt_port_enable,
  // memory interface clock
  input wire logic generator_clock_three,
  input wire logic mem_if_ext_clock_in,
  output logic mem_if_clock,
  // timer a shared pin
  input wire logic timer_a_output,
  input wire logic audio_data_line_2_out,
  input wire logic audio_data_line_2_oe_n,
  output logic audio_data_line_2_in,
  input wire logic timer_a_pad_in,
  output logic timer_a_pad_out,
  output logic timer_a_pad_oe_n,
  // timer b shared pin
  input wire logic timer_b_output,
  input wire logic audio_data_line_4_out,
  input wire logic audio_data_line_4_oe_n,
  output logic audio_data_line_4_in,
  input wire logic timer_b_pad_in,
  output logic timer_b_pad_out,
  output logic timer_b_pad_oe_n,
  // group a: serial a versus audio rx/tx clocks, frames, data 0 and 1
  input wire logic [6:0] serial_a_out,
  input wire logic [6:0] serial_a_oe_n,
  output logic [6:0] serial_a_in,
  input wire logic [6:0] audio_grp_a_out,
  input wire logic [6:0] audio_grp_a_oe_n,
  output logic [6:0] audio_grp_a_in,
  input wire logic [6:0] grp_a_pad_in,
  output logic [6:0] grp_a_pad_out,
  output logic [6:0] grp_a_pad_oe_n,
  // group b: serial b versus twowire b, audio data 7..5, mute
  input wire logic [5:0] serial_b_out,
  input wire logic [5:0] serial_b_oe_n,
  output logic [5:0] serial_b_in,
  input wire logic [5:0] alt_grp_b_out,
  input wire logic [5:0] alt_grp_b_oe_n,
  output logic [5:0] alt_grp_b_in,
  input wire logic [5:0] grp_b_pad_in,
  output logic [5:0] grp_b_pad_out,
  output logic [5:0] grp_b_pad_oe_n,
  // audio port restricted to transmitter mode
  output logic digital_audio_transmit_mode
);

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic [4:0] device_pin_config_reg;
  logic [4:0] device_pin_config_next;
  logic cfg_hit;
  logic strap_reg;
  logic mem_if_clock_source_sel;
  logic timer_a_pin_sel;
  logic timer_b_pin_sel;
  logic serial_port_a_pin_disable;
  logic serial_port_b_pin_disable;

  // only the page bits are compared, so any byte in the window aliases
  assign cfg_hit = (reg_addr[31:pin_config_pkg::CFG_PAGE_LSB] == pin_config_pkg::CFG_PAGE); // RULE15

  // reserved bits are dropped on write; software is expected to keep them zero
  assign device_pin_config_next = reg_wdata[pin_config_pkg::CFG_FIELD_W-1:0]; // RULE1

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  // writes are honoured at any time, not just after boot
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      device_pin_config_reg <= pin_config_pkg::CFG_RESET; // RULE17
    end else if (reg_wr && cfg_hit) begin
      device_pin_config_reg <= device_pin_config_next; // RULE12
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= pin_config_pkg::RDATA_IDLE;
    end else if (reg_rd && cfg_hit) begin
      reg_rdata <= {27'h0000000, device_pin_config_reg}; // RULE17
    end else begin
      reg_rdata <= pin_config_pkg::RDATA_IDLE;
    end
  end

  // field extraction
  assign mem_if_clock_source_sel = device_pin_config_reg[pin_config_pkg::MEM_CLK_SRC_BIT];
  assign timer_b_pin_sel = device_pin_config_reg[pin_config_pkg::TIMER_B_SEL_BIT];
  assign timer_a_pin_sel = device_pin_config_reg[pin_config_pkg::TIMER_A_SEL_BIT];
  assign serial_port_a_pin_disable = device_pin_config_reg[pin_config_pkg::SERIAL_A_DIS_BIT];
  assign serial_port_b_pin_disable = device_pin_config_reg[pin_config_pkg::SERIAL_B_DIS_BIT];

  // ---------------------------------------------------------------
  // memory interface clock source
  // ---------------------------------------------------------------
  // plain select: switching while both clocks run can glitch, so software
  // should change the source only while the memory interface is idle
  assign mem_if_clock = mem_if_clock_source_sel ? mem_if_ext_clock_in : generator_clock_three; // RULE2

  // ---------------------------------------------------------------
  // timer pins
  // ---------------------------------------------------------------
  // the timer output is only deselected here; the timer itself is never gated
  shared_pin_route #(
    .W(1)
  ) timer_a_route (
    .sel(timer_a_pin_sel), // RULE4
    .a_out(timer_a_output), // RULE5
    .a_oe_n(1'b0),
    .a_in(),
    .b_out(audio_data_line_2_out),
    .b_oe_n(audio_data_line_2_oe_n),
    .b_in(audio_data_line_2_in),
    .pin_in(timer_a_pad_in),
    .pin_out(timer_a_pad_out),
    .pin_oe_n(timer_a_pad_oe_n)
  );

  // each timer pin has its own select bit and no other bit reaches it
  shared_pin_route #(
    .W(1)
  ) timer_b_route (
    .sel(timer_b_pin_sel), // RULE3 RULE6
    .a_out(timer_b_output), // RULE5
    .a_oe_n(1'b0),
    .a_in(),
    .b_out(audio_data_line_4_out),
    .b_oe_n(audio_data_line_4_oe_n),
    .b_in(audio_data_line_4_in),
    .pin_in(timer_b_pad_in),
    .pin_out(timer_b_pad_out),
    .pin_oe_n(timer_b_pad_oe_n)
  );

  // ---------------------------------------------------------------
  // serial port pin groups
  // ---------------------------------------------------------------
  // group a: bit 1 hands the seven clock, frame and data pins to audio
  shared_pin_route #(
    .W(pin_config_pkg::GRP_A_W)
  ) grp_a_route (
    .sel(serial_port_a_pin_disable), // RULE7 RULE8
    .a_out(serial_a_out),
    .a_oe_n(serial_a_oe_n),
    .a_in(serial_a_in),
    .b_out(audio_grp_a_out),
    .b_oe_n(audio_grp_a_oe_n),
    .b_in(audio_grp_a_in),
    .pin_in(grp_a_pad_in),
    .pin_out(grp_a_pad_out),
    .pin_oe_n(grp_a_pad_oe_n)
  );

  // group b: twowire pins are open drain, their enable comes from the controller
  shared_pin_route #(
    .W(pin_config_pkg::GRP_B_W)
  ) grp_b_route (
    .sel(serial_port_b_pin_disable), // RULE10 RULE11
    .a_out(serial_b_out),
    .a_oe_n(serial_b_oe_n),
    .a_in(serial_b_in),
    .b_out(alt_grp_b_out),
    .b_oe_n(alt_grp_b_oe_n),
    .b_in(alt_grp_b_in),
    .pin_in(grp_b_pad_in),
    .pin_out(grp_b_pad_out),
    .pin_oe_n(grp_b_pad_oe_n)
  );

  // ---------------------------------------------------------------
  // audio transmitter-only mode
  // ---------------------------------------------------------------
  // without its clock and frame pins the audio port has no receive timing,
  // so only the self-clocked transmitter format can work
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      digital_audio_transmit_mode <= 1'b0;
    end else begin
      digital_audio_transmit_mode <= !serial_port_a_pin_disable &&
        (timer_a_pin_sel || timer_b_pin_sel || serial_port_b_pin_disable); // RULE9
    end
  end

  // ---------------------------------------------------------------
  // host port strap
  // ---------------------------------------------------------------
  strap_capture host_strap (
    .clk(clk),
    .sys_rst(sys_rst),
    .strap_pin(host_port_strap), // RULE13
    .strap_reg(strap_reg)
  );

  // the two enables are complements, so the pins never have two owners
  assign host_port_enable = strap_reg; // RULE16
  assign alt_port_enable = !strap_reg; // RULE14

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence cfg_write_s;
    reg_wr && cfg_hit;
  endsequence

  sequence cfg_read_s;
    reg_rd && cfg_hit;
  endsequence

  write_then_read_a: assert property (cfg_write_s ##1 cfg_read_s |=> // RULE17
    reg_rdata[4:0] == $past(reg_wdata[4:0], 2))
    else $error("read after write does not return written value");
  window_decode_a: assert property (reg_rd && reg_addr[31:8] == 24'h019c02 |=> // RULE15
    reg_rdata == {27'h0000000, $past(device_pin_config_reg)})
    else $error("window read returned wrong data");
  unmapped_read_a: assert property (!(reg_rd && cfg_hit) |=> reg_rdata == 32'h00000000) // RULE15
    else $error("read data outside a window read not zero");
  reserved_zero_a: assert property (reg_rdata[31:5] == 27'h0000000) // RULE1
    else $error("reserved bits read non-zero");
  write_update_a: assert property (cfg_write_s |=> // RULE12
    mem_if_clock_source_sel == $past(reg_wdata[4]) && serial_port_b_pin_disable == $past(reg_wdata[0]))
    else $error("configuration write did not take effect");
  clock_source_a: assert property (mem_if_clock == // RULE2
    (device_pin_config_reg[4] ? mem_if_ext_clock_in : generator_clock_three))
    else $error("memory interface clock from wrong source");
  timer_a_pin_a: assert property (!device_pin_config_reg[2] |-> // RULE4
    timer_a_pad_out == timer_a_output && !timer_a_pad_oe_n && !audio_data_line_2_in)
    else $error("timer a pin not owned by timer");
  timer_b_pin_a: assert property (device_pin_config_reg[3] |-> // RULE3
    timer_b_pad_out == audio_data_line_4_out && timer_b_pad_oe_n == audio_data_line_4_oe_n)
    else $error("timer b pin not given to audio");
  timer_indep_a: assert property ($stable(device_pin_config_reg[2]) && !device_pin_config_reg[2] |-> // RULE6
    timer_a_pad_out == timer_a_output)
    else $error("timer a pin disturbed by other bits");
  serial_a_own_a: assert property (!device_pin_config_reg[1] |-> // RULE7
    grp_a_pad_out == serial_a_out && audio_grp_a_in == 7'h00)
    else $error("serial a group routing wrong");
  audio_a_own_a: assert property (device_pin_config_reg[1] |-> // RULE8
    grp_a_pad_oe_n == audio_grp_a_oe_n && serial_a_in == 7'h00)
    else $error("audio group a routing wrong");
  serial_b_own_a: assert property (!device_pin_config_reg[0] |-> // RULE10
    grp_b_pad_oe_n == serial_b_oe_n && alt_grp_b_in == 6'h00)
    else $error("serial b group routing wrong");
  alt_b_own_a: assert property (device_pin_config_reg[0] |-> // RULE11
    grp_b_pad_out == alt_grp_b_out && serial_b_in == 6'h00)
    else $error("alternate group b routing wrong");
  transmit_only_a: assert property (##1 digital_audio_transmit_mode == // RULE9
    $past(!device_pin_config_reg[1] && (device_pin_config_reg[0] || device_pin_config_reg[2] ||
    device_pin_config_reg[3])))
    else $error("transmitter-only flag wrong");
  strap_frozen_a: assert property (##1 $stable(host_port_enable)) // RULE13
    else $error("host port ownership changed after reset");
  strap_exclusive_a: assert property (host_port_enable != alt_port_enable) // RULE14
    else $error("strapped pins have two or no owners");
  timer_b_keep_a: assert property (!device_pin_config_reg[3] |-> // RULE3 RULE5
    timer_b_pad_out == timer_b_output && !timer_b_pad_oe_n && !audio_data_line_4_in)
    else $error("timer b pin not owned by timer");
  timer_a_audio_a: assert property (device_pin_config_reg[2] |-> // RULE4
    timer_a_pad_out == audio_data_line_2_out && audio_data_line_2_in == timer_a_pad_in)
    else $error("timer a pin not given to audio");
  audio_a_input_a: assert property (device_pin_config_reg[1] |-> // RULE8
    audio_grp_a_in == grp_a_pad_in && grp_a_pad_out == audio_grp_a_out)
    else $error("audio group a inputs not routed from pads");

endmodule
`default_nettype wire

// [verilog/pin_config_pkg.sv]
// constants shared by the pin configuration multiplexer
`default_nettype none
package pin_config_pkg;
  // ---------------------------------------------------------------
  // register window and layout
  // ---------------------------------------------------------------
  localparam logic [31:0] CFG_BASE_ADDR = 32'h019c0200;
  localparam logic [23:0] CFG_PAGE = 24'h019c02;  // top 24 address bits of the 256-byte window
  localparam int CFG_PAGE_LSB = 8;
  localparam int CFG_FIELD_W = 5;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [31:0] RDATA_IDLE = 32'h00000000;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SERIAL_B_DIS_BIT = 0;
  localparam int SERIAL_A_DIS_BIT = 1;
  localparam int TIMER_A_SEL_BIT = 2;
  localparam int TIMER_B_SEL_BIT = 3;
  localparam int MEM_CLK_SRC_BIT = 4;
  // ---------------------------------------------------------------
  // pin group widths
  // ---------------------------------------------------------------
  localparam int GRP_A_W = 7;
  localparam int GRP_B_W = 6;
  localparam logic STRAP_RESET = 1'b1;  // unused: strap_reg has no value until a clock edge under reset samples the pin
endpackage
`default_nettype wire

// [verilog/shared_pin_route.sv]
// routes a group of shared pins to one of two peripherals
`timescale 1ns/1ns
`default_nettype none
module shared_pin_route #(
  parameter int W = 1
) (
  input wire logic sel,
  input wire logic [W-1:0] a_out,
  input wire logic [W-1:0] a_oe_n,
  output logic [W-1:0] a_in,
  input wire logic [W-1:0] b_out,
  input wire logic [W-1:0] b_oe_n,
  output logic [W-1:0] b_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_n
);
  // the deselected side sees zero and can never drive the pad
  always_comb begin
    pin_out = sel ? b_out : a_out;
    pin_oe_n = sel ? b_oe_n : a_oe_n;
    a_in = sel ? '0 : pin_in;
    b_in = sel ? pin_in : '0;
  end
endmodule
`default_nettype wire

// [verilog/strap_capture.sv]
// captures a pull-resistor strap while reset is held
`timescale 1ns/1ns
`default_nettype none
module strap_capture (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic strap_pin,
  output logic strap_reg
);
  // synchronous reset, so sampling the pin under reset is a clocked capture;
  // after release the value is frozen and nothing else can change it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strap_reg <= strap_pin;
    end
  end
endmodule
`default_nettype wire

// [bench/device_pin_config_mux_tb.sv]
// self-checking testbench for the pin configuration multiplexer
`timescale 1ns/1ns
`default_nettype none
module device_pin_config_mux_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk, sys_rst, reg_wr, reg_rd, host_port_strap, host_port_enable, alt_port_enable;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, seed, r;
  logic generator_clock_three, mem_if_ext_clock_in, mem_if_clock, digital_audio_transmit_mode;
  logic timer_a_output, audio_data_line_2_out, audio_data_line_2_oe_n, audio_data_line_2_in;
  logic timer_a_pad_in, timer_a_pad_out, timer_a_pad_oe_n;
  logic timer_b_output, audio_data_line_4_out, audio_data_line_4_oe_n, audio_data_line_4_in;
  logic timer_b_pad_in, timer_b_pad_out, timer_b_pad_oe_n;
  logic [6:0] serial_a_out, serial_a_oe_n, serial_a_in, audio_grp_a_out, audio_grp_a_oe_n, audio_grp_a_in;
  logic [6:0] grp_a_pad_in, grp_a_pad_out, grp_a_pad_oe_n;
  logic [5:0] serial_b_out, serial_b_oe_n, serial_b_in, alt_grp_b_out, alt_grp_b_oe_n, alt_grp_b_in;
  logic [5:0] grp_b_pad_in, grp_b_pad_out, grp_b_pad_oe_n;
  logic strap_val, rd_q;
  logic [31:0] exp_q[$];
  int n_errors, comparisons;

  device_pin_config_mux u_dut (
    .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .host_port_strap, .host_port_enable, .alt_port_enable,
    .generator_clock_three, .mem_if_ext_clock_in, .mem_if_clock,
    .timer_a_output, .audio_data_line_2_out, .audio_data_line_2_oe_n, .audio_data_line_2_in,
    .timer_a_pad_in, .timer_a_pad_out, .timer_a_pad_oe_n,
    .timer_b_output, .audio_data_line_4_out, .audio_data_line_4_oe_n, .audio_data_line_4_in,
    .timer_b_pad_in, .timer_b_pad_out, .timer_b_pad_oe_n,
    .serial_a_out, .serial_a_oe_n, .serial_a_in, .audio_grp_a_out, .audio_grp_a_oe_n, .audio_grp_a_in,
    .grp_a_pad_in, .grp_a_pad_out, .grp_a_pad_oe_n,
    .serial_b_out, .serial_b_oe_n, .serial_b_in, .alt_grp_b_out, .alt_grp_b_oe_n, .alt_grp_b_in,
    .grp_b_pad_in, .grp_b_pad_out, .grp_b_pad_oe_n,
    .digital_audio_transmit_mode
  );

  // ---------------------------------------------------------------
  // clock, watchdog and verdict
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // the whole sequence needs well under 300 cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  task automatic end_of_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // compare tasks and stimulus helpers
  // ---------------------------------------------------------------
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_read(input logic [31:0] got, input logic [31:0] exp);
    chk_pin(got, exp);
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // every peripheral and pad input gets fresh values so routing mistakes show up
  task automatic rand_in();
    r = xs();
    {timer_a_output, timer_b_output, audio_data_line_2_out, audio_data_line_2_oe_n, audio_data_line_4_out,
     audio_data_line_4_oe_n, timer_a_pad_in, timer_b_pad_in, generator_clock_three, mem_if_ext_clock_in,
     grp_a_pad_in, grp_b_pad_in} <= r[22:0];
    r = xs();
    {serial_a_out, serial_a_oe_n, audio_grp_a_out} <= r[20:0];
    r = xs();
    {audio_grp_a_oe_n, serial_b_out, serial_b_oe_n, alt_grp_b_out} <= r[24:0];
    r = xs();
    alt_grp_b_oe_n <= r[5:0];
  endtask

  // bus cycles start right after a rising edge and last one cycle
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // a function result cannot be part-selected directly, so it is held first
  function automatic logic [31:0] win_addr();
    logic [31:0] v;
    v = xs();
    return {pin_config_pkg::CFG_PAGE, v[7:0]};
  endfunction

  // pins are combinational; the transmit flag lags the register by one cycle
  task automatic check_pins(input logic [4:0] c);
    #1;
    chk_pin(32'(mem_if_clock), 32'(c[4] ? mem_if_ext_clock_in : generator_clock_three));
    chk_pin(32'({timer_a_pad_out, timer_a_pad_oe_n, audio_data_line_2_in}), 32'(c[2] ?
      {audio_data_line_2_out, audio_data_line_2_oe_n, timer_a_pad_in} : {timer_a_output, 2'b00}));
    chk_pin(32'({timer_b_pad_out, timer_b_pad_oe_n, audio_data_line_4_in}), 32'(c[3] ?
      {audio_data_line_4_out, audio_data_line_4_oe_n, timer_b_pad_in} : {timer_b_output, 2'b00}));
    chk_pin(32'({grp_a_pad_out, grp_a_pad_oe_n, serial_a_in, audio_grp_a_in}), 32'(c[1] ?
      {audio_grp_a_out, audio_grp_a_oe_n, 7'h00, grp_a_pad_in} :
      {serial_a_out, serial_a_oe_n, grp_a_pad_in, 7'h00}));
    chk_pin(32'({grp_b_pad_out, grp_b_pad_oe_n, serial_b_in, alt_grp_b_in}), 32'(c[0] ?
      {alt_grp_b_out, alt_grp_b_oe_n, 6'h00, grp_b_pad_in} :
      {serial_b_out, serial_b_oe_n, grp_b_pad_in, 6'h00}));
    chk_pin(32'(digital_audio_transmit_mode), 32'(!c[1] && (c[0] || c[2] || c[3])));
    chk_pin(32'({host_port_enable, alt_port_enable}), 32'({strap_val, !strap_val}));
  endtask

  // strap is flipped right after release to show that it stays frozen
  task automatic do_reset(input logic s);
    host_port_strap <= s;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    strap_val = s;
    @(posedge clk);
    host_port_strap <= !s;
    rand_in();
    rd(win_addr(), 32'h00000000);
    @(posedge clk);
    check_pins(5'h00);
  endtask

  // ---------------------------------------------------------------
  // read monitor: the oldest note is compared in the cycle after a read
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_q) begin
      chk_read(reg_rdata, exp_q.pop_front());
    end
    rd_q <= reg_rd;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'ha4c67708;
    rd_q = 1'b0;
    // reset is raised at time zero so no edge ever sees the unreset state
    {reg_wr, reg_rd} <= 2'b00;
    reg_addr <= 32'h00000000;
    reg_wdata <= 32'h00000000;
    rand_in();
    do_reset(1'b1);
    // every selection combination, each rewritten back to back with a read
    for (int c = 0; c < 32; c++) begin
      @(posedge clk);
      rand_in();
      wr(win_addr(), {27'h0000000, 5'(c)});
      rd(win_addr(), {27'h0000000, 5'(c)});
      check_pins(5'(c));
    end
    // outside the window: write ignored, read answers zero
    @(posedge clk);
    wr(32'h019c0300, 32'h00000005);
    rd(32'h019c01fc, 32'h00000000);
    // a spare edge so the read strobe is never assigned twice in one step
    @(posedge clk);
    rd(pin_config_pkg::CFG_BASE_ADDR, 32'h0000001f);
    check_pins(5'h1f);
    // second reset in mid-run with the other strap level
    @(posedge clk);
    do_reset(1'b0);
    @(posedge clk);
    wr(32'h019c02ff, 32'h0000000d);
    rd(32'h019c0280, 32'h0000000d);
    check_pins(5'h0d);
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
